// *** design/uhb_pkg.sv ***
// Shared constants and types for the host bus pin interface
package uhb_pkg;
    localparam int          UHB_DATA_W       = 8;
    localparam int          UHB_ADDR_W       = 8;
    localparam int          UHB_ADDR_IGNORED = 6;
    localparam int          UHB_GP_W         = 2;
    localparam int          UHB_REG_DEPTH    = 128;
    localparam int          UHB_RESET_SCLK   = 10;
    localparam int          UHB_CYCLE_LEN    = 4;
    localparam logic [7:0]  UHB_REG_RST      = 8'h00;
    localparam logic [7:0]  UHB_VECTOR_RST   = 8'h0F;
    localparam logic [7:0]  UHB_ADDR_GP_OUT  = 8'h3E;
    localparam logic [7:0]  UHB_ADDR_GP_IN   = 8'h3F;
    localparam logic [7:0]  UHB_ADDR_IRQ_SET = 8'h3D;
    localparam logic [7:0]  UHB_ADDR_IRQ_CLR = 8'h3C;
    localparam logic [7:0]  UHB_ADDR_VECTOR  = 8'h3B;
    localparam logic [3:0]  UHB_CNT_W        = 4'h0;
    typedef enum logic [1:0] {UHB_IDLE, UHB_BUSY, UHB_ACK, UHB_WAIT} uhb_phase_e;
endpackage

// *** design/uhb_bus_if.sv ***
// Pin-level bus between host and device, with wired resolution
`timescale 1ns/1ps
`default_nettype none
interface uhb_bus_if;
    import uhb_pkg::*;
    // Host driven pins
    logic                  chip_select_n;
    logic                  write_not_read;
    logic                  int_acknowledge_n;
    logic                  master_reset_n;
    logic [UHB_ADDR_W-1:0] addr;
    // Data bus drive from each side
    logic [UHB_DATA_W-1:0] host_data_out;
    logic                  host_data_oe;
    logic [UHB_DATA_W-1:0] dev_data_out;
    logic                  dev_data_oe;
    logic [UHB_DATA_W-1:0] data_in;
    // Open-drain outputs of the device
    logic                  transfer_ack_oe;
    logic                  interrupt_oe;
    logic                  transfer_ack_n;
    logic                  interrupt_request_n;
    // Resolved levels; pull-ups keep released lines high
    assign data_in = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '1);
    assign transfer_ack_n      = ~transfer_ack_oe;
    assign interrupt_request_n = ~interrupt_oe;
    modport device (
        input  chip_select_n, write_not_read, int_acknowledge_n, master_reset_n, addr, data_in,
        output dev_data_out, dev_data_oe, transfer_ack_oe, interrupt_oe
    );
    modport host (
        input  data_in, transfer_ack_n, interrupt_request_n,
        output chip_select_n, write_not_read, int_acknowledge_n, master_reset_n, addr,
        output host_data_out, host_data_oe
    );
endinterface
`default_nettype wire

// *** design/uhb_device.sv ***
// Device end: chip-selected register access, ack, interrupt and global I/O
// Functional notes
// (R01) Host drives write high, read low
// (R02) Access only while chip select low
// (R03) Chip select idle during interrupt acknowledge
// (R04) Pull acknowledge low when transfer completes
// (R05) Pull interrupt low while interrupts pend
// (R06) Low acknowledge input starts vector cycle
// (R07) Reset held at least ten clocks
// (R08) Address bit six ignored in decode
// (R09) One shared eight-bit bidirectional data bus
// (R10) System clock above twice comm clock
// (R11) Two global inputs, two global outputs
// (R12) Release bus when chip select withdrawn
`timescale 1ns/1ps
`default_nettype none
module uhb_device
    import uhb_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // Pin side
    uhb_bus_if.device                bus,
    // User side
    input  wire logic [UHB_GP_W-1:0] gp_in,
    output logic      [UHB_GP_W-1:0] gp_out,
    output logic      [7:0]          irq_pending
);
    // Address with the unused bit six dropped, giving a seven-bit index
    function automatic logic [6:0] uhb_index(input logic [7:0] a);
        uhb_index = {a[7], a[5:0]};
    endfunction

    logic [7:0]    regs [UHB_REG_DEPTH];
    logic [7:0]    next_wdata;
    logic          next_we;
    logic [6:0]    next_widx;
    logic [2:0]    sync_cs;
    logic [2:0]    sync_wr;
    logic [2:0]    sync_iack;
    logic [2:0]    sync_mrst;
    logic [2:0][1:0] sync_gp;
    logic          cs_act;
    logic          wr_lvl;
    logic          iack_act;
    logic          mrst_act;
    logic [1:0]    gp_lvl;
    uhb_phase_e    phase;
    uhb_phase_e    next_phase;
    logic [1:0]    cnt;
    logic [1:0]    next_cnt;
    logic          ack_oe;
    logic          next_ack_oe;
    logic [7:0]    dout;
    logic [7:0]    next_dout;
    logic          doe;
    logic          next_doe;
    logic [7:0]    pend;
    logic [7:0]    next_pend;
    logic [1:0]    gpo;
    logic [1:0]    next_gpo;
    logic          irq_oe;
    logic [7:0]    vector;
    logic [7:0]    next_vector;
    logic [7:0]    rdval;

    // Pin synchronisers, three stages; stages two and three must agree
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync_cs   <= 3'b111;
            sync_wr   <= 3'b000;
            sync_iack <= 3'b111;
            sync_gp   <= '0;
            cs_act    <= 1'b0;
            wr_lvl    <= 1'b0;
            iack_act  <= 1'b0;
            sync_mrst <= 3'b000;
            mrst_act  <= 1'b1;
            gp_lvl    <= 2'b00;
        end
        else
        begin
            sync_cs   <= {sync_cs[1:0], bus.chip_select_n};
            sync_wr   <= {sync_wr[1:0], bus.write_not_read};
            sync_iack <= {sync_iack[1:0], bus.int_acknowledge_n};
            sync_mrst <= {sync_mrst[1:0], bus.master_reset_n};
            sync_gp   <= {sync_gp[1:0], gp_in};
            if (sync_cs[2] == sync_cs[1])
                cs_act <= ~sync_cs[2];
            if (sync_wr[2] == sync_wr[1])
                wr_lvl <= sync_wr[2];
            if (sync_iack[2] == sync_iack[1])
                iack_act <= ~sync_iack[2];
            if (sync_mrst[2] == sync_mrst[1])
                mrst_act <= ~sync_mrst[2];
            for (int i = 0; i < UHB_GP_W; i++)
                if (sync_gp[2][i] == sync_gp[1][i])
                    gp_lvl[i] <= sync_gp[2][i];
        end
    end

    // Read value by decoded address
    always_comb
    begin
        rdval = regs[uhb_index(bus.addr)];                          // R08
        if (uhb_index(bus.addr) == uhb_index(UHB_ADDR_GP_IN))
            rdval = {6'h00, gp_lvl};                                // R11
        else if (uhb_index(bus.addr) == uhb_index(UHB_ADDR_GP_OUT))
            rdval = {6'h00, gpo};
        else if (uhb_index(bus.addr) == uhb_index(UHB_ADDR_IRQ_SET))
            rdval = pend;
    end

    // Bus cycle sequencer: three busy clocks per access (count 1 to 3), then ack
    always_comb
    begin
        next_phase  = phase;
        next_cnt    = cnt;
        next_ack_oe = 1'b0;
        next_dout   = dout;
        next_doe    = doe;
        next_we     = 1'b0;
        next_widx   = uhb_index(bus.addr);
        next_wdata  = bus.data_in;
        next_vector = vector;
        next_pend   = pend;
        next_gpo    = gpo;
        case (phase)
            UHB_IDLE:
            begin
                next_doe = 1'b0;
                if (cs_act && !iack_act)                            // R02
                begin
                    next_phase = UHB_BUSY;
                    next_cnt   = 2'd1;
                end
                else if (iack_act && !cs_act)                       // R06
                begin
                    next_phase = UHB_BUSY;
                    next_cnt   = 2'd1;
                end
            end
            UHB_BUSY:
            begin
                next_cnt = cnt + 2'd1;
                if (!wr_lvl || iack_act)                            // R09
                begin
                    next_doe  = 1'b1;
                    next_dout = iack_act ? vector : rdval;
                end
                if (cnt == 2'(UHB_CYCLE_LEN - 1))
                begin
                    next_phase  = UHB_ACK;
                    next_ack_oe = 1'b1;                             // R04
                    if (cs_act && wr_lvl)                           // R02
                    begin
                        next_we = 1'b1;
                        if (next_widx == uhb_index(UHB_ADDR_GP_OUT))
                            next_gpo = bus.data_in[1:0];            // R11
                        else if (next_widx == uhb_index(UHB_ADDR_IRQ_SET))
                            next_pend = pend | bus.data_in;
                        else if (next_widx == uhb_index(UHB_ADDR_IRQ_CLR))
                            next_pend = pend & ~bus.data_in;
                        else if (next_widx == uhb_index(UHB_ADDR_VECTOR))
                            next_vector = bus.data_in;
                    end
                end
                if (!cs_act && !iack_act)                           // R12
                begin
                    next_phase  = UHB_IDLE;
                    next_doe    = 1'b0;
                    next_we     = 1'b0;
                    next_ack_oe = 1'b0;
                    next_gpo    = gpo;
                    next_pend   = pend;
                    next_vector = vector;
                end
            end
            UHB_ACK:
            begin
                next_ack_oe = 1'b1;
                next_phase  = UHB_WAIT;
            end
            default:
            begin
                // Hold until chip select and acknowledge are both withdrawn
                if (!cs_act && !iack_act)                           // R12
                begin
                    next_phase = UHB_IDLE;
                    next_doe   = 1'b0;
                end
            end
        endcase
        if (mrst_act)                                               // R07
        begin
            next_phase  = UHB_IDLE;
            next_cnt    = 2'd0;
            next_ack_oe = 1'b0;
            next_doe    = 1'b0;
            next_we     = 1'b0;
            next_pend   = UHB_REG_RST;
            next_gpo    = 2'b00;
            next_vector = UHB_VECTOR_RST;
        end
    end

    // Sequencer and output registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            phase  <= UHB_IDLE;
            cnt    <= 2'd0;
            ack_oe <= 1'b0;
            dout   <= UHB_REG_RST;
            doe    <= 1'b0;
            pend   <= UHB_REG_RST;
            gpo    <= 2'b00;
            vector <= UHB_VECTOR_RST;
            irq_oe <= 1'b0;
        end
        else
        begin
            phase  <= next_phase;
            cnt    <= next_cnt;
            ack_oe <= next_ack_oe;
            dout   <= next_dout;
            doe    <= next_doe;
            pend   <= next_pend;
            gpo    <= next_gpo;
            vector <= next_vector;
            irq_oe <= |next_pend;                                   // R05
        end
    end

    // Register storage, no reset on the array
    always_ff @(posedge mclk)
    begin
        if (next_we)
            regs[next_widx] <= next_wdata;
    end

    // Pin and user outputs
    assign bus.dev_data_out    = dout;
    assign bus.dev_data_oe     = doe;
    assign bus.transfer_ack_oe = ack_oe;
    assign bus.interrupt_oe    = irq_oe;
    assign gp_out              = gpo;
    assign irq_pending         = pend;
endmodule
`default_nettype wire

// *** design/uhb_host.sv ***
// Host end: drives single register accesses and interrupt acknowledge cycles
`timescale 1ns/1ps
`default_nettype none
module uhb_host
    import uhb_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Pin side
    uhb_bus_if.host           bus,
    // User request
    input  wire logic         req,
    input  wire logic         req_write,
    input  wire logic         req_iack,
    input  wire logic [7:0]   req_addr,
    input  wire logic [7:0]   req_wdata,
    input  wire logic         reset_req,
    // User answer
    output logic              busy,
    output logic              done,
    output logic [7:0]        rdata,
    output logic              irq_seen
);
    typedef enum logic [1:0] {UHB_H_IDLE, UHB_H_RUN, UHB_H_RST, UHB_H_GAP} uhb_hstate_e;
    uhb_hstate_e st;
    uhb_hstate_e next_st;
    logic [3:0]  rcnt;
    logic [3:0]  next_rcnt;
    logic        cs_n, next_cs_n, wr, next_wr, iack_n, next_iack_n, mrst_n, next_mrst_n;
    logic [7:0]  addr, next_addr, wd, next_wd, rd, next_rd;
    logic        oe, next_oe, dn, next_dn;
    logic [2:0]  ack_s, irq_s;

    // Next-state for host cycles
    always_comb
    begin
        next_st = st; next_rcnt = rcnt; next_cs_n = cs_n; next_wr = wr;
        next_iack_n = iack_n; next_mrst_n = mrst_n; next_addr = addr;
        next_wd = wd; next_rd = rd; next_oe = oe; next_dn = 1'b0;
        case (st)
            UHB_H_IDLE:
            begin
                if (reset_req)
                begin
                    next_st = UHB_H_RST; next_mrst_n = 1'b0; next_rcnt = 4'd0;
                end
                else if (req)
                begin
                    next_st   = UHB_H_RUN;
                    next_addr = req_addr;
                    next_wd   = req_wdata;
                    next_wr   = req_write & ~req_iack;              // R01
                    next_oe   = req_write & ~req_iack;              // R09
                    next_cs_n   = req_iack;                         // R03
                    next_iack_n = ~req_iack;
                end
            end
            UHB_H_RUN:
            begin
                if (ack_s[2] == ack_s[1] && !ack_s[2])
                begin
                    next_rd = bus.data_in;
                    next_cs_n = 1'b1; next_iack_n = 1'b1; next_oe = 1'b0;
                    next_dn = 1'b1; next_st = UHB_H_GAP; next_rcnt = 4'd0;
                end
            end
            UHB_H_GAP:
            begin
                // Chip select stays idle long enough for the device to see release
                next_rcnt = rcnt + 4'd1;
                if (rcnt == 4'(UHB_CYCLE_LEN - 1))
                    next_st = UHB_H_IDLE;
            end
            default:
            begin
                next_rcnt = rcnt + 4'd1;
                if (rcnt == 4'(UHB_RESET_SCLK - 1))                 // R07
                begin
                    next_mrst_n = 1'b1; next_st = UHB_H_IDLE;
                end
            end
        endcase
    end

    // Host registers and pin synchronisers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st <= UHB_H_RST; rcnt <= 4'd0; cs_n <= 1'b1; wr <= 1'b0;
            iack_n <= 1'b1; mrst_n <= 1'b0; addr <= 8'h00; wd <= 8'h00;
            rd <= 8'h00; oe <= 1'b0; dn <= 1'b0; ack_s <= 3'b111; irq_s <= 3'b111;
            irq_seen <= 1'b0;
            busy <= 1'b1;
        end
        else
        begin
            st <= next_st; rcnt <= next_rcnt; cs_n <= next_cs_n; wr <= next_wr;
            iack_n <= next_iack_n; mrst_n <= next_mrst_n; addr <= next_addr;
            wd <= next_wd; rd <= next_rd; oe <= next_oe; dn <= next_dn;
            ack_s <= {ack_s[1:0], bus.transfer_ack_n};
            irq_s <= {irq_s[1:0], bus.interrupt_request_n};
            busy <= (next_st != UHB_H_IDLE);
            if (irq_s[2] == irq_s[1])
                irq_seen <= ~irq_s[2];
        end
    end

    // Pin and user outputs
    assign bus.chip_select_n     = cs_n;
    assign bus.write_not_read    = wr;
    assign bus.int_acknowledge_n = iack_n;
    assign bus.master_reset_n    = mrst_n;
    assign bus.addr              = {addr[7], 1'b0, addr[5:0]};
    assign bus.host_data_out     = wd;
    assign bus.host_data_oe      = oe;
    assign done  = dn;
    assign rdata = rd;
endmodule
`default_nettype wire

// *** dv/uhb_properties.sv ***
// Concurrent checks on the host bus pins between host and device
`timescale 1ns/1ps
`default_nettype none
module uhb_properties
    import uhb_pkg::*;
(
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  rst,
    // Bus pins
    input wire logic                  chip_select_n,
    input wire logic                  write_not_read,
    input wire logic                  int_acknowledge_n,
    input wire logic                  master_reset_n,
    input wire logic [UHB_ADDR_W-1:0] addr,
    input wire logic                  host_data_oe,
    input wire logic                  dev_data_oe,
    input wire logic                  transfer_ack_oe,
    input wire logic                  interrupt_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Pin relations
    host_drive_dir_a: assert property (host_data_oe |-> write_not_read && !chip_select_n)
        else $error("host drives data outside a write");
    cs_hold_a: assert property ($fell(chip_select_n) |-> !chip_select_n [*4])
        else $error("chip select dropped early");
    no_overlap_a: assert property (!int_acknowledge_n |-> chip_select_n)
        else $error("chip select during vector cycle");
    ack_cause_a: assert property ($rose(transfer_ack_oe) |->
        !$past(chip_select_n, 3) || !$past(int_acknowledge_n, 3))
        else $error("ack without access");
    ack_width_a: assert property ($rose(transfer_ack_oe) |=> transfer_ack_oe)
        else $error("ack shorter than two cycles");
    reset_width_a: assert property ($fell(master_reset_n) |=> !master_reset_n [*8] ##1
        !master_reset_n)
        else $error("master reset too short");
    addr_bit_a: assert property (!chip_select_n |-> addr[UHB_ADDR_IGNORED] == 1'b0)
        else $error("unused address bit driven");
    dev_drive_dir_a: assert property ($rose(dev_data_oe) |->
        (chip_select_n ? !int_acknowledge_n : !write_not_read))
        else $error("device drives data outside a read");
    bus_release_a: assert property ((chip_select_n && int_acknowledge_n) [*6] |->
        !dev_data_oe && !transfer_ack_oe)
        else $error("device holds bus after release");
    // Main scenarios
    cov_write_c: cover property (!chip_select_n && write_not_read && transfer_ack_oe);
    cov_read_c: cover property (!chip_select_n && !write_not_read && dev_data_oe);
    cov_iack_c: cover property (!int_acknowledge_n && transfer_ack_oe);
    cov_irq_c: cover property ($rose(interrupt_oe));
endmodule
`default_nettype wire

// *** dv/uhb_tb_top.sv ***
// Testbench joining host and device ends over the pin bus
`timescale 1ns/1ps
`default_nettype none
module uhb_tb_top;
    import uhb_pkg::*;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       req = 1'b0;
    logic       req_write = 1'b0;
    logic       req_iack = 1'b0;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_wdata = 8'h00;
    logic       reset_req = 1'b0;
    logic [1:0] gp_in = 2'b00;
    logic       busy;
    logic       done;
    logic [7:0] rdata;
    logic       irq_seen;
    logic [1:0] gp_out;
    logic [7:0] irq_pending;
    logic [8:0] notes[$];
    logic [8:0] note;
    logic [31:0] seed = 32'h2f3b;
    logic [7:0] a;
    logic [7:0] d;
    int         mismatches = 0;
    int         comparisons = 0;
    // Clock at 50 MHz
    always #10 mclk = ~mclk;
    uhb_bus_if uhb_bus_if_i ();
    uhb_device uhb_device_i (.mclk(mclk), .rst(rst), .bus(uhb_bus_if_i), .gp_in(gp_in),
        .gp_out(gp_out), .irq_pending(irq_pending));
    uhb_host uhb_host_i (.mclk(mclk), .rst(rst), .bus(uhb_bus_if_i), .req(req),
        .req_write(req_write), .req_iack(req_iack), .req_addr(req_addr),
        .req_wdata(req_wdata), .reset_req(reset_req), .busy(busy), .done(done),
        .rdata(rdata), .irq_seen(irq_seen));
    uhb_properties uhb_properties_i (.mclk(mclk), .rst(rst),
        .chip_select_n(uhb_bus_if_i.chip_select_n),
        .write_not_read(uhb_bus_if_i.write_not_read),
        .int_acknowledge_n(uhb_bus_if_i.int_acknowledge_n),
        .master_reset_n(uhb_bus_if_i.master_reset_n), .addr(uhb_bus_if_i.addr),
        .host_data_oe(uhb_bus_if_i.host_data_oe), .dev_data_oe(uhb_bus_if_i.dev_data_oe),
        .transfer_ack_oe(uhb_bus_if_i.transfer_ack_oe),
        .interrupt_oe(uhb_bus_if_i.interrupt_oe));
    // Pseudo random source
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Single compare with report
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Wait for host idle under a bound
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge mclk);
            #2;
            n++;
        end
        if (n >= 200)
            mismatches++;
    endtask
    // One host access; note[8] marks a read to compare
    task automatic access(input logic w, input logic ia, input logic [7:0] ad,
                          input logic [7:0] wd, input logic [8:0] exp_note);
        wait_idle();
        req = 1'b1;
        req_write = w;
        req_iack = ia;
        req_addr = ad;
        req_wdata = wd;
        notes.push_back(exp_note);
        @(posedge mclk);
        #2;
        req = 1'b0;
        @(posedge mclk);
        #2;
        wait_idle();
    endtask
    // Wait for the interrupt line to reach a level, then compare
    task automatic irq_level(input logic lvl);
        int n;
        n = 0;
        while ((uhb_bus_if_i.interrupt_request_n !== lvl || irq_seen !== ~lvl) && n < 20)
        begin
            @(posedge mclk);
            #2;
            n++;
        end
        compare({7'h00, uhb_bus_if_i.interrupt_request_n}, {7'h00, lvl});
        compare({7'h00, irq_seen}, {7'h00, ~lvl});
    endtask
    // Result watcher takes the oldest note at each done, mid-cycle
    always @(negedge mclk)
    begin
        if (done === 1'b1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            if (note[8])
                compare(rdata, note[7:0]);
        end
    end
    // Watchdog
    initial
    begin
        #(20 * 20000);
        mismatches++;
        results();
    end
    // Main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        #2;
        rst = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            seed = xorshift(seed);
            a = {seed[7], 2'b00, seed[4:0]};
            d = seed[15:8];
            access(1'b1, 1'b0, a, d, {1'b0, d});
            access(1'b0, 1'b0, a | 8'h40, 8'h00, {1'b1, d});
        end
        seed = xorshift(seed);
        gp_in = seed[1:0];
        access(1'b1, 1'b0, UHB_ADDR_GP_OUT, seed[15:8], 9'h000);
        compare({6'h00, gp_out}, {6'h00, seed[9:8]});
        access(1'b0, 1'b0, UHB_ADDR_GP_IN, 8'h00, {3'b100, 4'h0, seed[1:0]});
        irq_level(1'b1);
        access(1'b1, 1'b0, UHB_ADDR_IRQ_SET, 8'h05, 9'h000);
        compare(irq_pending, 8'h05);
        irq_level(1'b0);
        access(1'b0, 1'b1, 8'h00, 8'h00, {1'b1, UHB_VECTOR_RST});
        access(1'b0, 1'b0, UHB_ADDR_IRQ_SET, 8'h00, 9'h105);
        access(1'b1, 1'b0, UHB_ADDR_IRQ_CLR, 8'h05, 9'h000);
        compare(irq_pending, 8'h00);
        irq_level(1'b1);
        access(1'b1, 1'b0, UHB_ADDR_VECTOR, seed[23:16], 9'h000);
        access(1'b0, 1'b1, 8'h00, 8'h00, {1'b1, seed[23:16]});
        access(1'b1, 1'b0, UHB_ADDR_IRQ_SET, 8'h05, 9'h000);
        reset_req = 1'b1;
        @(posedge mclk);
        #2;
        reset_req = 1'b0;
        @(posedge mclk);
        #2;
        compare({7'h00, busy}, 8'h01);
        access(1'b0, 1'b0, a, 8'h00, {1'b1, d});
        compare(irq_pending, UHB_REG_RST);
        compare({6'h00, gp_out}, 8'h00);
        irq_level(1'b1);
        access(1'b0, 1'b1, 8'h00, 8'h00, {1'b1, UHB_VECTOR_RST});
        compare(8'(notes.size()), 8'h00);
        repeat (4) @(posedge mclk);
        results();
    end
endmodule
`default_nettype wire
